/* File: core/upt_map.vh */
// Register map, field positions and reset values for the USB power and test control block
`ifndef UPT_MAP_VH
`define UPT_MAP_VH

`define UPT_ADDR_W 4
`define UPT_OFF_PWRC 4'h0
`define UPT_OFF_CNFG1 4'h1
`define UPT_OFF_STAT 4'h2
`define UPT_OFF_CLR 4'h3
`define UPT_OFF_IEN 4'h4

`define UPT_PWRC_POWER 0
`define UPT_PWRC_SUSPEND 1
`define UPT_PWRC_GUARD 4
`define UPT_PWRC_PEND 7
`define UPT_CNFG1_SIDL 4
`define UPT_CNFG1_EYE 7

`define UPT_ST_ACT 0
`define UPT_ST_WAKE 1
`define UPT_ST_W 2

`define UPT_RST_BYTE 8'h00
`define UPT_RST_ST 2'h0
`define UPT_ZERO32 32'h0000_0000
`define UPT_RD_DEAD 32'h0000_0000

`endif

/* File: core/upt_control.v */
// USB power-saving, sleep guard, idle gating and eye pattern control with Avalon-MM registers
`timescale 1ns/1ps
`include "upt_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Setting the suspend request bit 1 of the power control register puts the module in Suspend.
// - With the enable set, any bus activity raises the activity interrupt, which can wake from Sleep.
// - Software sets sleep guard bit 4 before its sleep-sensitive code to warn of coming Sleep.
// - Activity pending bit 7 shows a pending activity interrupt; software sleeps only when clear.
// - In Idle with stop-in-idle clear, only the CPU clock is gated and the module keeps running.
// - While the CPU idles with the module clocked, any enabled interrupt wakes the CPU.
// - In Idle with stop-in-idle set, the module clock is gated too and normal operation stops.
// - With the module clock gated in Idle, an enabled activity interrupt still wakes the CPU.
// - With the eye pattern bit set, the module sends J-K-J-K while the bit stays set and it is powered, out of Suspend and not clock-gated.
// - Every reset source returns all registers to defaults, leaving the module turned off.
// - After reset nothing is guaranteed about descriptor table or packet buffer contents.
// - Interrupt flags stay set until software writes a one to their bit position.
module upt_control #(
    parameter DATA_W = 32
) (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire [`UPT_ADDR_W-1:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [DATA_W-1:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [DATA_W-1:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    input wire BUS_ACTIVITY,
    input wire CPU_IDLE,
    input wire MODULE_EVENT,
    output reg SUSPEND_OUT,
    output reg SIE_CLK_EN,
    output reg CPU_WAKE,
    output reg EYE_TX_ACTIVE,
    output reg EYE_TX_J,
    output reg IRQ
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg act_meta;
reg act_sync;
reg act_prev;
reg idle_meta;
reg idle_sync;

always @(posedge REF_CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        act_meta <= 1'b0;
        act_sync <= 1'b0;
        act_prev <= 1'b0;
        idle_meta <= 1'b0;
        idle_sync <= 1'b0;
    end
    else
    begin
        act_meta <= BUS_ACTIVITY;
        act_sync <= act_meta;
        act_prev <= act_sync;
        idle_meta <= CPU_IDLE;
        idle_sync <= idle_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [7:0] power_control_reg;
reg [7:0] config_reg_one;
reg [`UPT_ST_W-1:0] status;
reg [`UPT_ST_W-1:0] irq_enable;
reg access_done;

function sel;
    input [`UPT_ADDR_W-1:0] a;
    input [`UPT_ADDR_W-1:0] off;
    begin
        sel = (a == off);
    end
endfunction

wire req = (AVS_READ | AVS_WRITE) & ~access_done;
// Write lands on the completing edge, where the master sees waitrequest low
wire wr = AVS_WRITE & access_done & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
wire activity_edge = act_sync & ~act_prev;
wire module_gated = idle_sync & config_reg_one[`UPT_CNFG1_SIDL];
// Gated module still sees the bus activity detector, which is unclocked by the SIE
wire [`UPT_ST_W-1:0] events = {MODULE_EVENT & ~module_gated, activity_edge};
wire [`UPT_ST_W-1:0] clr_mask = (wr && sel(AVS_ADDRESS, `UPT_OFF_CLR)) ?
    AVS_WRITEDATA[`UPT_ST_W-1:0] : `UPT_RST_ST;
wire activity_pend = status[`UPT_ST_ACT] & irq_enable[`UPT_ST_ACT];
// No descriptor table or packet RAM lives here, so reset promises nothing for them

always @(posedge REF_CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        power_control_reg <= `UPT_RST_BYTE;
        config_reg_one <= `UPT_RST_BYTE;
        status <= `UPT_RST_ST;
        irq_enable <= `UPT_RST_ST;
        access_done <= 1'b0;
        AVS_WAITREQUEST <= 1'b1;
        AVS_READDATA <= `UPT_ZERO32;
    end
    else
    begin
        // Set wins over a clear in the same cycle
        status <= (status & ~clr_mask) | events;
        access_done <= req;
        AVS_WAITREQUEST <= ~req;
        if (wr && sel(AVS_ADDRESS, `UPT_OFF_PWRC))
        begin
            power_control_reg[`UPT_PWRC_POWER] <= AVS_WRITEDATA[`UPT_PWRC_POWER];
            power_control_reg[`UPT_PWRC_SUSPEND] <= AVS_WRITEDATA[`UPT_PWRC_SUSPEND];
            power_control_reg[`UPT_PWRC_GUARD] <= AVS_WRITEDATA[`UPT_PWRC_GUARD];
        end
        if (wr && sel(AVS_ADDRESS, `UPT_OFF_CNFG1))
        begin
            config_reg_one[`UPT_CNFG1_SIDL] <= AVS_WRITEDATA[`UPT_CNFG1_SIDL];
            config_reg_one[`UPT_CNFG1_EYE] <= AVS_WRITEDATA[`UPT_CNFG1_EYE];
        end
        if (wr && sel(AVS_ADDRESS, `UPT_OFF_IEN))
            irq_enable <= AVS_WRITEDATA[`UPT_ST_W-1:0];
        if (AVS_READ && req)
        begin
            case (AVS_ADDRESS)
                `UPT_OFF_PWRC:
                begin
                    AVS_READDATA <= `UPT_ZERO32;
                    AVS_READDATA[6:0] <= power_control_reg[6:0];
                    AVS_READDATA[`UPT_PWRC_PEND] <= activity_pend;
                end
                `UPT_OFF_CNFG1:
                begin
                    AVS_READDATA <= `UPT_ZERO32;
                    AVS_READDATA[7:0] <= config_reg_one;
                end
                `UPT_OFF_STAT:
                begin
                    AVS_READDATA <= `UPT_ZERO32;
                    AVS_READDATA[`UPT_ST_W-1:0] <= status;
                end
                `UPT_OFF_IEN:
                begin
                    AVS_READDATA <= `UPT_ZERO32;
                    AVS_READDATA[`UPT_ST_W-1:0] <= irq_enable;
                end
                default:
                    AVS_READDATA <= `UPT_RD_DEAD;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Power, idle and eye pattern outputs
wire powered = power_control_reg[`UPT_PWRC_POWER];
wire suspended = power_control_reg[`UPT_PWRC_SUSPEND];
wire eye_on = config_reg_one[`UPT_CNFG1_EYE] & powered & ~suspended & ~module_gated;
wire any_irq = |(status & irq_enable);

always @(posedge REF_CLK or posedge SYS_RST)
begin
    if (SYS_RST)
    begin
        SUSPEND_OUT <= 1'b0;
        SIE_CLK_EN <= 1'b0;
        CPU_WAKE <= 1'b0;
        EYE_TX_ACTIVE <= 1'b0;
        EYE_TX_J <= 1'b1;
        IRQ <= 1'b0;
    end
    else
    begin
        SUSPEND_OUT <= suspended;
        SIE_CLK_EN <= powered & ~suspended & ~module_gated;
        // Gated: only the activity flag may wake; clocked: any enabled flag
        CPU_WAKE <= idle_sync & (module_gated ? activity_pend : any_irq);
        IRQ <= any_irq;
        EYE_TX_ACTIVE <= eye_on;
        if (eye_on)
            EYE_TX_J <= ~EYE_TX_J;
        else
            EYE_TX_J <= 1'b1;
    end
end

endmodule // upt_control

/* File: tb/upt_bus_model.sv */
// Far-side USB bus model driving line activity
`timescale 1ns/1ps
module upt_bus_model (
    input wire REF_CLK,
    input wire send,
    output reg BUS_ACTIVITY
);
    initial BUS_ACTIVITY = 1'b0;
    // Idle bus rests low so no stray edge reaches the wake logic
    always @(posedge REF_CLK)
        BUS_ACTIVITY <= send & ~BUS_ACTIVITY;
endmodule // upt_bus_model

/* File: tb/upt_monitor.sv */
// Port assertions for the USB power and test control block
`timescale 1ns/1ps
module upt_monitor (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire AVS_WAITREQUEST,
    input wire CPU_IDLE,
    input wire SUSPEND_OUT,
    input wire SIE_CLK_EN,
    input wire CPU_WAKE,
    input wire EYE_TX_ACTIVE,
    input wire EYE_TX_J,
    input wire IRQ
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    property p_wait_one; $fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_answer; $rose(AVS_READ || AVS_WRITE) |-> ##[1:3] !AVS_WAITREQUEST; endproperty
    a_answer: assert property (p_answer) else $error("no bus answer");
    property p_sus; SUSPEND_OUT && $past(SUSPEND_OUT) |-> !SIE_CLK_EN && !EYE_TX_ACTIVE; endproperty
    a_sus: assert property (p_sus) else $error("runs in suspend");
    property p_tog; EYE_TX_ACTIVE && $past(EYE_TX_ACTIVE) |-> EYE_TX_J != $past(EYE_TX_J); endproperty
    a_tog: assert property (p_tog) else $error("pattern stuck");
    property p_idle_j; !EYE_TX_ACTIVE && !$past(EYE_TX_ACTIVE) |-> EYE_TX_J; endproperty
    a_idle_j: assert property (p_idle_j) else $error("pattern idle level");
    // Write excluded: IRQ is registered, so it drops one cycle after a clear completes
    property p_sticky; IRQ && !AVS_WRITE && !$past(AVS_WRITE) |=> IRQ; endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_idle_wake; (CPU_IDLE && IRQ && SIE_CLK_EN) [*4] |-> CPU_WAKE; endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("no wake");
    property p_wake_src; CPU_WAKE |-> IRQ || $past(IRQ); endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake without flag");
endmodule // upt_monitor
bind upt_control upt_monitor i_mon (.*);

/* File: tb/tb_top.sv */
// Directed bench for the USB power and test control block
`timescale 1ns/1ps
module tb_top;
    reg REF_CLK = 1'b0, SYS_RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    reg CPU_IDLE = 1'b0, MODULE_EVENT = 1'b0, send = 1'b0;
    reg [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
    reg [31:0] AVS_WRITEDATA = 32'h0000_0000, q;
    wire [31:0] AVS_READDATA;
    wire AVS_WAITREQUEST, BUS_ACTIVITY, SUSPEND_OUT, SIE_CLK_EN, CPU_WAKE, EYE_TX_ACTIVE, EYE_TX_J, IRQ;
    integer n_errors = 0, tests_run = 0, i;
    upt_control i_dut (
        .REF_CLK(REF_CLK),
        .SYS_RST(SYS_RST),
        .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .BUS_ACTIVITY(BUS_ACTIVITY),
        .CPU_IDLE(CPU_IDLE),
        .MODULE_EVENT(MODULE_EVENT),
        .SUSPEND_OUT(SUSPEND_OUT),
        .SIE_CLK_EN(SIE_CLK_EN),
        .CPU_WAKE(CPU_WAKE),
        .EYE_TX_ACTIVE(EYE_TX_ACTIVE),
        .EYE_TX_J(EYE_TX_J),
        .IRQ(IRQ)
    );
    upt_bus_model i_bus (.REF_CLK(REF_CLK), .send(send), .BUS_ACTIVITY(BUS_ACTIVITY));
    initial forever #10 REF_CLK = ~REF_CLK;
    ////////////////////////////////////////////////////////////////////////////////
    task tick(input integer n); repeat (n) @(posedge REF_CLK); endtask
    task bus(input w, input [3:0] a, input [31:0] d);
    begin
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        tick(1);
        while (AVS_WAITREQUEST !== 1'b0) tick(1);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        tick(1);
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    end
    endtask
    task rd(input [3:0] a, input [31:0] exp); begin bus(0, a, 0); chk(q, exp); end endtask
    task pulse; begin send <= 1'b1; tick(6); send <= 1'b0; end endtask
    task close_out;
    begin
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
    begin
        for (integer a = 0; a < 8; a = a + 1) if (a != 3) rd(a[3:0], 32'h0);
        chk(SIE_CLK_EN, 0);
    end
    endtask
    task t_suspend;
    begin
        bus(1, 4'h0, 32'h03);
        tick(2);
        chk({SUSPEND_OUT, SIE_CLK_EN}, 2'h2);
        rd(4'h0, 32'h03);
        bus(1, 4'h0, 32'h01);
        tick(2);
        chk(SIE_CLK_EN, 1);
    end
    endtask
    task t_act;
    begin
        bus(1, 4'h4, 32'h01);
        bus(1, 4'h0, 32'h11);
        pulse;
        for (i = 0; i < 20 && IRQ !== 1'b1; i = i + 1) tick(1);
        chk(IRQ, 1);
        rd(4'h0, 32'h91);
        bus(1, 4'h2, 32'h00);
        bus(1, 4'h3, 32'h02);
        rd(4'h2, 32'h01);
        bus(1, 4'h3, 32'h01);
        tick(2);
        chk(IRQ, 0);
        rd(4'h0, 32'h11);
    end
    endtask
    task t_idle;
    begin
        bus(1, 4'h1, 32'h10);
        CPU_IDLE <= 1'b1;
        tick(6);
        chk({SIE_CLK_EN, CPU_WAKE}, 2'h0);
        MODULE_EVENT <= 1'b1;
        tick(1);
        MODULE_EVENT <= 1'b0;
        pulse;
        tick(6);
        chk(CPU_WAKE, 1);
        rd(4'h2, 32'h01);
        bus(1, 4'h1, 32'h00);
        bus(1, 4'h3, 32'h03);
        bus(1, 4'h4, 32'h02);
        MODULE_EVENT <= 1'b1;
        tick(1);
        MODULE_EVENT <= 1'b0;
        tick(8);
        chk({SIE_CLK_EN, CPU_WAKE}, 2'h3);
        CPU_IDLE <= 1'b0;
        bus(1, 4'h3, 32'h03);
    end
    endtask
    task t_eye;
    begin
        bus(1, 4'h1, 32'h80);
        tick(4);
        chk(EYE_TX_ACTIVE, 1);
        q = EYE_TX_J;
        tick(1);
        chk(EYE_TX_J, !q[0]);
        bus(1, 4'h0, 32'h03);
        tick(3);
        chk(EYE_TX_ACTIVE, 0);
        SYS_RST <= 1'b1;
        tick(2);
        SYS_RST <= 1'b0;
        tick(1);
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h0);
        chk({SUSPEND_OUT, SIE_CLK_EN, EYE_TX_J}, 3'h1);
    end
    endtask
    initial
    begin
        tick(20);
        SYS_RST <= 1'b0;
        tick(1);
        t_reset;
        t_suspend;
        t_act;
        t_idle;
        t_eye;
        close_out;
    end
    // Whole run is under two hundred cycles; this only catches a hung handshake
    initial
    begin
        tick(5000);
        n_errors = n_errors + 1;
        close_out;
    end
endmodule // tb_top
